// file: inc/nand_cfg_defines.svh
// Notes on behaviour
// RULE_01 - Timing field value N means N+1 cycles
// RULE_02 - Separate read and write setup/strobe/hold widths
// RULE_03 - Select-strobe bit clear runs normal strobe mode
// RULE_04 - Extended-wait bit clear inserts no wait cycles
// RULE_05 - Wait config ignored while extended wait disabled
// RULE_06 - Bus-width field zero selects 8-bit data
// RULE_07 - NAND-mode bit per space 2 to 5
// RULE_08 - ECC-start bit per space, set before data
// RULE_09 - Programmable turnaround between read and write
// RULE_10 - Host issues command, address, data as accesses
// RULE_11 - Turnaround keeps write drive off read data
// RULE_12 - Config regs 32-bit RW, used next access
`ifndef NAND_CFG_DEFINES_SVH
`define NAND_CFG_DEFINES_SVH

// Register byte offsets
`define OFS_WAIT_CFG 8'h04
`define OFS_ASYNC_CFG0 8'h10
`define ASYNC_CFG_MASK 8'hF3
`define OFS_NAND_CTL 8'h60
`define OFS_STATUS 8'h64
`define OFS_XFER_WR 8'h80
`define OFS_XFER_RD 8'h84
`define OFS_RD_DATA 8'h88

// Reset values and writable-bit masks
`define RST_WAIT_CFG 32'hF0E40080
`define MASK_WAIT_CFG 32'hF0FF00FF
`define RST_ASYNC_CFG 32'h3FFFFFFC
`define RST_NAND_CTL 32'h00000000
`define MASK_NAND_CTL 32'h00000F0F

// Field positions
`define NAND_EN_LSB 0
`define ECC_START_LSB 8
`define WAIT_MAX_LSB 0
`define WAIT_MAP_LSB 16
`define WAIT_POL_LSB 28

// Encodings
`define BUS_WIDTH_8BIT 2'h0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: inc/nand_cfg_pkg.sv
package nand_cfg_pkg;

  typedef enum logic [2:0] {
    ST_IDLE, ST_TURN, ST_SETUP, ST_STROBE, ST_XWAIT, ST_HOLD
  } engine_state_e;

  // One chip-select space configuration word
  typedef struct packed {
    logic ss;
    logic extended_wait_enable;
    logic [3:0] w_setup;
    logic [5:0] w_strobe;
    logic [2:0] w_hold;
    logic [3:0] r_setup;
    logic [5:0] r_strobe;
    logic [2:0] r_hold;
    logic [1:0] turnaround_cycles;
    logic [1:0] bus_width_select;
  } async_cfg_s;

  // Word software writes to queue one external access
  typedef struct packed {
    logic [1:0] space;
    logic [13:0] addr;
    logic [15:0] data;
  } xfer_word_s;

  typedef struct packed {
    logic is_read;
    xfer_word_s w;
  } xfer_s;

  typedef struct packed {
    logic [3:0] cs_n;
    logic oe_n;
    logic we_n;
    logic [1:0] data_oe;
    logic [13:0] addr;
    logic [15:0] dout;
  } pin_s;

  typedef struct packed {
    logic [23:0] pad;
    logic rd_valid;
    logic fifo_full;
    logic fifo_empty;
    logic busy;
    logic [3:0] wait_in;
  } status_s;

endpackage

// file: design/cycle_timer.sv
module cycle_timer #(
  parameter int W = 8
) (
  input wire logic aclk, // Controller clock
  input wire logic aresetn, // Sync reset, active low
  input wire logic load, // Start a new phase
  input wire logic [W-1:0] value, // Phase length minus one
  output logic done // Last cycle of the phase
);
  logic [W-1:0] cnt_reg;

  // Down counter, reaching zero marks the final cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= '0;
    end else if (load) begin
      cnt_reg <= value;
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end

  assign done = (cnt_reg == '0);
endmodule // cycle_timer

// file: design/cmd_fifo.sv
module cmd_fifo #(
  parameter int WIDTH = 35,
  parameter int DEPTH = 16
) (
  input wire logic aclk, // Controller clock
  input wire logic aresetn, // Sync reset, active low
  input wire logic in_valid, // Push request
  output logic in_ready, // Room for a word
  input wire logic [WIDTH-1:0] in_data, // Pushed word
  output logic out_valid, // Word available
  input wire logic out_ready, // Pop request
  output logic [WIDTH-1:0] out_data, // Head word
  output logic full, // No room left
  output logic empty // Nothing stored
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_reg;
  logic [AW:0] rd_ptr_reg;

  // Extra pointer bit tells full from empty; depth must be a power of two
  assign empty = (wr_ptr_reg == rd_ptr_reg);
  assign full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rd_ptr_reg[AW-1:0]];

  // Pointers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (in_valid && in_ready) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (out_valid && out_ready) rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end

  // Storage, no reset needed
  always_ff @(posedge aclk) begin
    if (in_valid && in_ready) mem[wr_ptr_reg[AW-1:0]] <= in_data;
  end
endmodule // cmd_fifo

// file: design/async_memory_nand_timing_config.sv
`include "nand_cfg_defines.svh"

module async_memory_nand_timing_config
  import nand_cfg_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic aclk, // 50 MHz controller clock
  input wire logic aresetn, // Sync reset, active low
  input wire logic [7:0] awaddr, // AXI write address
  input wire logic awvalid, // AXI write address valid
  output logic awready, // AXI write address ready
  input wire logic [31:0] wdata, // AXI write data
  input wire logic [3:0] wstrb, // AXI byte strobes
  input wire logic wvalid, // AXI write data valid
  output logic wready, // AXI write data ready
  output logic [1:0] bresp, // AXI write response
  output logic bvalid, // AXI write response valid
  input wire logic bready, // AXI write response ready
  input wire logic [7:0] araddr, // AXI read address
  input wire logic arvalid, // AXI read address valid
  output logic arready, // AXI read address ready
  output logic [31:0] rdata, // AXI read data
  output logic [1:0] rresp, // AXI read response
  output logic rvalid, // AXI read data valid
  input wire logic rready, // AXI read data ready
  output logic [3:0] external_chip_select_n, // Spaces 2 to 5, low active
  output logic external_output_enable_n, // Read strobe, low active
  output logic external_write_enable_n, // Write strobe, low active
  output logic [13:0] ext_addr, // External address
  output logic [15:0] ext_data_out, // External data driven
  output logic [1:0] ext_data_oe, // Per byte lane drive enable
  input wire logic [15:0] ext_data_in, // External data sampled
  input wire logic [3:0] external_wait_input, // Wait pins 2 to 5
  output logic [3:0] nand_mode, // NAND mode per space
  output logic [3:0] ecc_active // ECC start per NAND space
);
  logic [31:0] wait_cfg_reg;
  logic [31:0] async_cfg_reg [4];
  logic [31:0] nand_ctl_reg;
  logic aw_full_reg, w_full_reg, bvalid_reg, rvalid_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg, rdata_reg;
  logic [3:0] w_strb_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic wr_is_xfer, wr_mapped, wr_go, fifo_in_valid, fifo_in_ready;
  logic fifo_out_valid, fifo_full, fifo_empty, pop, timer_done, timer_load;
  logic [31:0] wr_mask, rd_mux;
  logic rd_mapped, rd_take, last_read_reg, wait_act, rd_valid_reg;
  xfer_s fifo_in, fifo_out, cur_reg, cur_next;
  async_cfg_s cfg_reg, cfg_next;
  engine_state_e state_reg, state_next;
  logic [7:0] timer_val, phase_cnt_reg;
  logic [15:0] rd_data_reg;
  pin_s pin_reg, pin_next;
  status_s status;

  // AXI write channels: capture address and data in either order
  assign awready = !aw_full_reg;
  assign wready = !w_full_reg;
  assign wr_is_xfer = (aw_addr_reg == `OFS_XFER_WR) || (aw_addr_reg == `OFS_XFER_RD);
  assign wr_mapped = wr_is_xfer || (aw_addr_reg == `OFS_WAIT_CFG) ||
                     ((aw_addr_reg & `ASYNC_CFG_MASK) == `OFS_ASYNC_CFG0) ||
                     (aw_addr_reg == `OFS_NAND_CTL) || (aw_addr_reg == `OFS_STATUS) ||
                     (aw_addr_reg == `OFS_RD_DATA);
  // A full queue holds the write open, so back-pressure reaches the master
  assign fifo_in_valid = aw_full_reg && w_full_reg && !bvalid_reg && wr_is_xfer;
  assign wr_go = aw_full_reg && w_full_reg && !bvalid_reg && (!wr_is_xfer || fifo_in_ready);
  assign fifo_in = '{is_read: (aw_addr_reg == `OFS_XFER_RD), w: xfer_word_s'(w_data_reg)};

  always_comb begin
    for (int b = 0; b < 4; b++) wr_mask[b*8 +: 8] = {8{w_strb_reg[b]}};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
    end else if (wr_go) begin
      aw_full_reg <= 1'b0;
    end else if (awvalid && awready) begin
      aw_full_reg <= 1'b1;
      aw_addr_reg <= awaddr;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
    end else if (wr_go) begin
      w_full_reg <= 1'b0;
    end else if (wvalid && wready) begin
      w_full_reg <= 1'b1;
      w_data_reg <= wdata;
      w_strb_reg <= wstrb;
    end
  end

  // Response follows both halves; unmapped offsets answer SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `RESP_OKAY;
    end else if (wr_go) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
    end else if (bready) begin
      bvalid_reg <= 1'b0;
    end
  end
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;

  // Configuration registers, byte lanes honoured, reserved bits stay zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wait_cfg_reg <= `RST_WAIT_CFG;
      nand_ctl_reg <= `RST_NAND_CTL;
    end else if (wr_go) begin
      if (aw_addr_reg == `OFS_WAIT_CFG)
        wait_cfg_reg <= ((wait_cfg_reg & ~wr_mask) | (w_data_reg & wr_mask)) & `MASK_WAIT_CFG;
      if (aw_addr_reg == `OFS_NAND_CTL) // RULE_07 RULE_08 RULE_12
        nand_ctl_reg <= ((nand_ctl_reg & ~wr_mask) | (w_data_reg & wr_mask)) & `MASK_NAND_CTL;
    end
  end

  for (genvar i = 0; i < 4; i++) begin : g_space
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        async_cfg_reg[i] <= `RST_ASYNC_CFG;
      end else if (wr_go && (aw_addr_reg == (`OFS_ASYNC_CFG0 + 8'(4 * i)))) begin
        async_cfg_reg[i] <= (async_cfg_reg[i] & ~wr_mask) | (w_data_reg & wr_mask); // RULE_12
      end
    end
  end

  // NAND mode and ECC start handed to the NAND datapath per space
  assign nand_mode = nand_ctl_reg[`NAND_EN_LSB +: 4]; // RULE_07
  assign ecc_active = nand_mode & nand_ctl_reg[`ECC_START_LSB +: 4]; // RULE_08

  // Read mux over the register map
  assign status = '{pad: 24'h000000, rd_valid: rd_valid_reg, fifo_full: fifo_full,
                    fifo_empty: fifo_empty, busy: (state_reg != ST_IDLE) || !fifo_empty,
                    wait_in: external_wait_input};
  always_comb begin
    rd_mux = 32'h00000000;
    rd_mapped = 1'b1;
    if (araddr == `OFS_WAIT_CFG) rd_mux = wait_cfg_reg;
    else if ((araddr & `ASYNC_CFG_MASK) == `OFS_ASYNC_CFG0) rd_mux = async_cfg_reg[araddr[3:2]];
    else if (araddr == `OFS_NAND_CTL) rd_mux = nand_ctl_reg;
    else if (araddr == `OFS_STATUS) rd_mux = 32'(status);
    else if (araddr == `OFS_RD_DATA) rd_mux = {16'h0000, rd_data_reg};
    else if (araddr == `OFS_XFER_WR || araddr == `OFS_XFER_RD) rd_mux = 32'h00000000;
    else rd_mapped = 1'b0;
  end

  assign arready = !rvalid_reg;
  assign rd_take = arvalid && arready;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= `RESP_OKAY;
    end else if (rd_take) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_mux;
      rresp_reg <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rready) begin
      rvalid_reg <= 1'b0;
    end
  end
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;

  // Queue of single external accesses; command, address and data phases
  // of a NAND operation arrive here one by one from software
  cmd_fifo #(.WIDTH($bits(xfer_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(fifo_out_valid),
    .out_ready(pop),
    .out_data(fifo_out),
    .full(fifo_full),
    .empty(fifo_empty)
  ); // RULE_10

  // Config latched at access start, so a later write affects the next one
  assign pop = (state_reg == ST_IDLE) && fifo_out_valid;
  assign cur_next = pop ? fifo_out : cur_reg;
  assign cfg_next = pop ? async_cfg_s'(async_cfg_reg[fifo_out.w.space]) : cfg_reg; // RULE_12

  // Wait pin for this space, polarity from the wait config
  always_comb begin
    logic [1:0] pin;
    pin = wait_cfg_reg[`WAIT_MAP_LSB + 2*cur_reg.w.space +: 2];
    wait_act = (external_wait_input[pin] == wait_cfg_reg[`WAIT_POL_LSB + pin]);
  end

  // Access sequencer
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: if (fifo_out_valid) // RULE_09 RULE_11
        state_next = (!fifo_out.is_read && last_read_reg) ? ST_TURN : ST_SETUP;
      ST_TURN: if (timer_done) state_next = ST_SETUP;
      ST_SETUP: if (timer_done) state_next = ST_STROBE;
      ST_STROBE: if (timer_done) // RULE_04 RULE_05
        state_next = (cfg_reg.extended_wait_enable && wait_act) ? ST_XWAIT : ST_HOLD;
      ST_XWAIT: if (timer_done || !wait_act) state_next = ST_HOLD;
      ST_HOLD: if (timer_done) state_next = ST_IDLE;
    endcase
  end

  // Phase lengths: field value N gives N+1 cycles
  always_comb begin
    timer_val = 8'h00;
    unique case (state_next)
      ST_TURN: timer_val = 8'(cfg_next.turnaround_cycles); // RULE_01 RULE_09
      ST_SETUP: timer_val = cur_next.is_read ? 8'(cfg_next.r_setup) : 8'(cfg_next.w_setup);
      ST_STROBE: timer_val = cur_next.is_read ? 8'(cfg_next.r_strobe) : 8'(cfg_next.w_strobe);
      ST_XWAIT: timer_val = wait_cfg_reg[`WAIT_MAX_LSB +: 8];
      ST_HOLD: timer_val = cur_next.is_read ? 8'(cfg_next.r_hold) : 8'(cfg_next.w_hold); // RULE_02
      default: timer_val = 8'h00;
    endcase
  end
  assign timer_load = (state_next != state_reg);

  cycle_timer #(.W(8)) u_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(timer_load),
    .value(timer_val),
    .done(timer_done)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_IDLE;
      cur_reg <= '0;
      cfg_reg <= '0;
    end else begin
      state_reg <= state_next;
      cur_reg <= cur_next;
      cfg_reg <= cfg_next;
    end
  end

  // Remember a finished read so the next write waits out turnaround
  always_ff @(posedge aclk) begin
    if (!aresetn) last_read_reg <= 1'b0;
    else if (state_reg == ST_HOLD && timer_done) last_read_reg <= cur_reg.is_read; // RULE_11
  end

  // Read data sampled on the last strobe cycle; 8-bit space zero-fills
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_data_reg <= 16'h0000;
      rd_valid_reg <= 1'b0;
    end else if (cur_reg.is_read && state_next == ST_HOLD && state_reg != ST_HOLD) begin
      rd_data_reg <= (cfg_reg.bus_width_select == `BUS_WIDTH_8BIT) ?
                     {8'h00, ext_data_in[7:0]} : ext_data_in;
      rd_valid_reg <= 1'b1; // Set beats a simultaneous clear
    end else if (rd_take && araddr == `OFS_RD_DATA) begin
      rd_valid_reg <= 1'b0;
    end
  end

  // Pin decode from next state, registered so pins are glitch free
  always_comb begin
    logic active, strobe;
    active = (state_next inside {ST_SETUP, ST_STROBE, ST_XWAIT, ST_HOLD});
    strobe = (state_next inside {ST_STROBE, ST_XWAIT});
    pin_next = '{cs_n: 4'hF, oe_n: 1'b1, we_n: 1'b1, data_oe: 2'h0,
                 addr: cur_next.w.addr, dout: cur_next.w.data};
    // Normal mode holds select across setup to hold; NAND spaces always do
    if (active && (!cfg_next.ss || nand_mode[cur_next.w.space] || strobe)) // RULE_03
      pin_next.cs_n[cur_next.w.space] = 1'b0;
    pin_next.oe_n = !(strobe && cur_next.is_read);
    pin_next.we_n = !(strobe && !cur_next.is_read);
    if (active && !cur_next.is_read) // RULE_06
      pin_next.data_oe = (cfg_next.bus_width_select == `BUS_WIDTH_8BIT) ? 2'h1 : 2'h3;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) pin_reg <= '{cs_n: 4'hF, oe_n: 1'b1, we_n: 1'b1, data_oe: 2'h0,
                               addr: 14'h0000, dout: 16'h0000};
    else pin_reg <= pin_next;
  end
  assign external_chip_select_n = pin_reg.cs_n;
  assign external_output_enable_n = pin_reg.oe_n;
  assign external_write_enable_n = pin_reg.we_n;
  assign ext_addr = pin_reg.addr;
  assign ext_data_out = pin_reg.dout;
  assign ext_data_oe = pin_reg.data_oe;

  // Cycles spent in the current phase, for the checks below
  always_ff @(posedge aclk) begin
    if (!aresetn || state_next != state_reg) phase_cnt_reg <= 8'h00;
    else phase_cnt_reg <= phase_cnt_reg + 8'h01;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_SETUP_LEN: assert property ((state_reg == ST_SETUP && state_next != ST_SETUP) // RULE_01
    |-> phase_cnt_reg == (cur_reg.is_read ? 8'(cfg_reg.r_setup) : 8'(cfg_reg.w_setup)))
    else $error("setup phase length wrong");
  AST_STROBE_LEN: assert property ((state_reg == ST_STROBE && state_next != ST_STROBE) // RULE_02
    |-> phase_cnt_reg == (cur_reg.is_read ? 8'(cfg_reg.r_strobe) : 8'(cfg_reg.w_strobe)))
    else $error("strobe phase length wrong");
  AST_HOLD_LEN: assert property ((state_reg == ST_HOLD && state_next == ST_IDLE) // RULE_02
    |-> phase_cnt_reg == (cur_reg.is_read ? 8'(cfg_reg.r_hold) : 8'(cfg_reg.w_hold)))
    else $error("hold phase length wrong");
  AST_TURN_LEN: assert property ($fell(state_reg == ST_TURN) |-> // RULE_09
    $past(phase_cnt_reg) == 8'($past(cfg_reg.turnaround_cycles)) && state_reg == ST_SETUP)
    else $error("turnaround length wrong");
  AST_NORMAL_CS: assert property ((state_reg == ST_SETUP && !cfg_reg.ss) |-> // RULE_03
    external_chip_select_n[cur_reg.w.space] == 1'b0)
    else $error("select not held in normal mode");
  AST_NO_XWAIT: assert property (state_reg == ST_XWAIT |-> // RULE_04
    cfg_reg.extended_wait_enable) else $error("wait inserted while disabled");
  AST_WAITCFG_IGN: assert property (state_reg == ST_STROBE && timer_done && // RULE_05
    !cfg_reg.extended_wait_enable |=> state_reg == ST_HOLD)
    else $error("strobe not ended by its own count");
  AST_BYTE_LANE: assert property (state_reg == ST_SETUP && // RULE_06
    cfg_reg.bus_width_select == `BUS_WIDTH_8BIT |-> !ext_data_oe[1])
    else $error("upper lane driven on 8-bit space");
  AST_NO_CONTENTION: assert property (state_reg == ST_IDLE && // RULE_11
    state_next == ST_SETUP && !fifo_out.is_read |-> !last_read_reg ##1 ext_data_oe != 2'h0)
    else $error("write follows read without turnaround");
  AST_CFG_TAKE: assert property (wr_go && aw_addr_reg == `OFS_NAND_CTL && // RULE_12
    w_strb_reg == 4'hF |=> nand_ctl_reg == ($past(w_data_reg) & `MASK_NAND_CTL))
    else $error("control write not stored");
endmodule // async_memory_nand_timing_config

// file: dv/nand_flash_model.sv
module nand_flash_model (
  input wire logic aclk, // Bench clock, drives idle pattern
  input wire logic cs_n, // Select, low active
  input wire logic oe_n, // Read strobe, low active
  input wire logic we_n, // Write strobe, low active
  input wire logic [7:0] din, // Byte lane 0 from controller
  output logic [15:0] dout // Bus as seen by controller
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem_reg = 8'h00;
  logic [15:0] junk_reg = 16'h3C96;
  logic we_q = 1'b1;
  // Each command, address or data phase arrives as its own write strobe
  always @(posedge aclk) begin
    we_q <= we_n;
    junk_reg <= ~junk_reg;
    if (!cs_n && we_n && !we_q) begin
      mem_reg <= din;
    end
  end
  // Released bus toggles every cycle so a stale byte never passes
  assign dout = (!cs_n && !oe_n) ? {junk_reg[15:8], mem_reg} : junk_reg;
endmodule // nand_flash_model

// file: dv/tb.sv
`include "nand_cfg_defines.svh"

module tb
  import nand_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [3:0] wait_in = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, oe_n, we_n;
  logic [1:0] bresp, rresp, doe;
  logic [31:0] rdata;
  logic [3:0] cs_n, nmode, ecc;
  logic [13:0] addr;
  logic [15:0] dout, din;
  int n_fail = 0;
  int checks_done = 0;
  int cs_c = 0;
  int we_c = 0;
  int oe_c = 0;
  int gap = 0;
  int gap_l = 0;
  int len_l = 0;
  int we_l = 0;
  int oe_l = 0;
  int gww;
  logic [1:0] lanes = 2'b00;
  logic [31:0] d;
  logic [1:0] r;
  async_cfg_s cfg;

  async_memory_nand_timing_config dut (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready,
    .external_chip_select_n(cs_n),
    .external_output_enable_n(oe_n),
    .external_write_enable_n(we_n),
    .ext_addr(addr),
    .ext_data_out(dout),
    .ext_data_oe(doe),
    .ext_data_in(din),
    .external_wait_input(wait_in),
    .nand_mode(nmode),
    .ecc_active(ecc)
  );

  nand_flash_model flash (
    .aclk(aclk),
    .cs_n(cs_n[0]),
    .oe_n(oe_n),
    .we_n(we_n),
    .din(dout[7:0]),
    .dout(din)
  );

  // 50 MHz clock
  always #10 aclk = ~aclk;

  // Measure select length, strobe widths and idle gap for space 2
  always @(posedge aclk) begin
    if (!oe_n && doe !== 2'b00) begin
      chk("drive_during_read", 32'h1, 32'h0);
    end
    if (cs_n[0] === 1'b0) begin
      if (cs_c == 0) begin
        gap_l <= gap;
      end
      cs_c <= cs_c + 1;
      gap <= 0;
      we_c <= we_c + (we_n ? 0 : 1);
      oe_c <= oe_c + (oe_n ? 0 : 1);
      lanes <= lanes | doe;
    end else begin
      gap <= gap + 1;
      if (cs_c != 0) begin
        len_l <= cs_c;
        we_l <= we_c;
        oe_l <= oe_c;
      end
      cs_c <= 0;
      we_c <= 0;
      oe_c <= 0;
    end
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Sampling at the falling edge reads what the next rising edge will see
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic ha, hw, hb;
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    hb = 1'b0;
    n = 0;
    rs = 2'h0;
    while (!hb && n < 200) begin
      @(negedge aclk);
      ha = awvalid & awready;
      hw = wvalid & wready;
      hb = bvalid;
      rs = bresp;
      @(posedge aclk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      n++;
    end
    bready <= 1'b0;
    chk("bvalid", {31'h0, hb}, 32'h1);
    if (!hb) final_report();
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic ha, hr;
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    hr = 1'b0;
    n = 0;
    while (!hr && n < 200) begin
      @(negedge aclk);
      ha = arvalid & arready;
      hr = rvalid;
      v = rdata;
      rs = rresp;
      @(posedge aclk);
      if (ha) arvalid <= 1'b0;
      n++;
    end
    rready <= 1'b0;
    chk("rvalid", {31'h0, hr}, 32'h1);
    if (!hr) final_report();
  endtask

  // Poll until the queue is empty and the sequencer idle
  task automatic drain();
    logic [31:0] s;
    logic [1:0] rs;
    int n;
    s = 32'h0;
    n = 0;
    while (s[5:4] !== 2'b10 && n < 100) begin
      rd(`OFS_STATUS, s, rs);
      n++;
    end
    chk("drain", {30'h0, s[5:4]}, 32'h2);
    if (s[5:4] !== 2'b10) final_report();
    repeat (3) @(posedge aclk);
  endtask

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`OFS_WAIT_CFG, d, r);
    chk("wait_cfg", d, `RST_WAIT_CFG);
    rd(`OFS_ASYNC_CFG0, d, r);
    chk("async_cfg", d, `RST_ASYNC_CFG);
    rd(`OFS_NAND_CTL, d, r);
    chk("nand_ctl", d, `RST_NAND_CTL);
    rd(8'h30, d, r);
    chk("rresp_unmapped", {30'h0, r}, {30'h0, `RESP_SLVERR});
    wr(8'h30, 32'h1, r);
    chk("bresp_unmapped", {30'h0, r}, {30'h0, `RESP_SLVERR});
    // Normal mode, no extended wait, 8-bit bus; wait pins held active
    cfg = '0;
    cfg.w_strobe = 6'h06;
    cfg.w_hold = 3'h1;
    cfg.r_setup = 4'h2;
    cfg.r_strobe = 6'h07;
    cfg.turnaround_cycles = 2'h2;
    cfg.bus_width_select = `BUS_WIDTH_8BIT;
    wr(`OFS_ASYNC_CFG0, cfg, r);
    rd(`OFS_ASYNC_CFG0, d, r);
    chk("cfg_readback", d, cfg);
    for (int i = 0; i < 4; i++) begin
      wr(`OFS_NAND_CTL, 32'h101 << i, r);
      chk("nand_mode", {28'h0, nmode}, 32'h1 << i);
      chk("ecc_active", {28'h0, ecc}, 32'h1 << i);
    end
    wr(`OFS_NAND_CTL, 32'hFFFFFFFF, r);
    rd(`OFS_NAND_CTL, d, r);
    chk("nand_ctl_mask", d, `MASK_NAND_CTL);
    wr(`OFS_NAND_CTL, 32'h00000F01, r);
    chk("ecc_gated", {28'h0, ecc}, 32'h1);
    // ECC start left clear while the command and address go out
    wr(`OFS_NAND_CTL, 32'h00000001, r);
    wr(`OFS_XFER_WR, {2'h0, 14'h0001, 16'h0070}, r);
    wr(`OFS_XFER_WR, {2'h0, 14'h0002, 16'h005A}, r);
    drain();
    chk("w_select", len_l, cfg.w_setup + cfg.w_strobe + cfg.w_hold + 3);
    chk("ext_addr", {18'h0, addr}, 32'h2);
    chk("w_strobe", we_l, cfg.w_strobe + 1);
    gww = gap_l;
    wr(`OFS_XFER_RD, {2'h0, 14'h0003, 16'h0000}, r);
    drain();
    chk("r_select", len_l, cfg.r_setup + cfg.r_strobe + cfg.r_hold + 3);
    chk("r_strobe", oe_l, cfg.r_strobe + 1);
    rd(`OFS_RD_DATA, d, r);
    chk("rd_data", d, 32'h0000005A);
    wr(`OFS_XFER_RD, {2'h0, 14'h0003, 16'h0000}, r);
    wr(`OFS_XFER_WR, {2'h0, 14'h0004, 16'h00A5}, r);
    drain();
    chk("turnaround", gap_l, gww + cfg.turnaround_cycles + 1);
    chk("lanes", {30'h0, lanes}, 32'h1);
    // Select strobe, NAND off, 16-bit bus, wait active: strobe plus four wait cycles
    wr(`OFS_NAND_CTL, 32'h00000000, r);
    wr(`OFS_WAIT_CFG, 32'hF0E40003, r);
    cfg.ss = 1'b1;
    cfg.extended_wait_enable = 1'b1;
    cfg.bus_width_select = 2'h1;
    wr(`OFS_ASYNC_CFG0, cfg, r);
    wr(`OFS_XFER_WR, {2'h0, 14'h0005, 16'h1234}, r);
    drain();
    chk("ss_select", len_l, cfg.w_strobe + 5);
    chk("xwait_strobe", we_l, cfg.w_strobe + 5);
    chk("lanes16", {30'h0, lanes}, 32'h3);
    chk("ext_addr_ss", {18'h0, addr}, 32'h5);
    final_report();
  end
endmodule // tb
